//--- include/rcc_pkg.sv
package rcc_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 50;
  localparam int MCLK_HZ = 600_000;
  localparam int MCLK_DIV = CLK_HZ / MCLK_HZ;
  localparam int TRIG_MIN_NS = 1_000;
  localparam int TRIG_MAX_NS = 16_000_000;
  localparam int TRIG_MIN_CYC = (TRIG_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRIG_MAX_CYC = TRIG_MAX_NS / CLK_NS;
  localparam int TRIG_HOLD_NS = 100_000;
  localparam int TRIG_HOLD_CYC = (TRIG_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------
  // Conversion counts in master clock counts, then counter and result widths and line counts
  // ----------------------------------------
  localparam int AZ_COUNTS = 10_000;
  localparam int INT_COUNTS = 10_000;
  localparam int REF_TIMEOUT = 20_000;
  localparam int CNT_W = 16;
  localparam int RES_W = 15;
  localparam int MODE_N = 4;
  localparam int RANGE_N = 7;
  // ----------------------------------------
  // Controller register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RANGE_LSB = 4;
  localparam int CTRL_HOLD = 11;
  localparam int CTRL_CONT = 12;
  localparam int CTRL_START = 13;
  localparam int CTRL_W = 13;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0000;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVER = 1;
  localparam int IRQ_BLOCK = 2;
  localparam int IRQ_W = 3;
  // ----------------------------------------
  // Converter phases
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    PH_AZ = 2'b00,
    PH_INTEG = 2'b01,
    PH_DEINT = 2'b10
  } rcc_phase_e;
endpackage

//--- include/rcc_link_if.sv
`timescale 1ns/1ps
interface rcc_link_if;
  logic trigger;
  logic hold_n;
  logic [rcc_pkg::MODE_N-1:0] mode_dev_oe;
  logic [rcc_pkg::MODE_N-1:0] mode_host_oe;
  logic [rcc_pkg::MODE_N-1:0] mode_n;
  logic [rcc_pkg::RANGE_N-1:0] range_dev_oe;
  logic [rcc_pkg::RANGE_N-1:0] range_host_oe;
  logic [rcc_pkg::RANGE_N-1:0] range_n;
  logic mode_busy;
  logic range_busy;
  logic data_valid;
  logic ready;
  logic sign;
  logic [rcc_pkg::RES_W-1:0] result;

  // Open-collector lines: low while either end pulls
  assign mode_n = ~(mode_dev_oe | mode_host_oe);
  assign range_n = ~(range_dev_oe | range_host_oe);

  modport dev
  (
    input trigger, hold_n, mode_n, range_n,
    output mode_dev_oe, range_dev_oe, mode_busy, range_busy, data_valid, ready, sign, result
  );
  modport host
  (
    input mode_n, range_n, mode_busy, range_busy, data_valid, ready, sign, result,
    output trigger, hold_n, mode_host_oe, range_host_oe
  );
endinterface

//--- logic/rcc_device.sv
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module rcc_device #(
  parameter int MCLK_DIV = rcc_pkg::MCLK_DIV,
  parameter int AZ_COUNTS = rcc_pkg::AZ_COUNTS,
  parameter int INT_COUNTS = rcc_pkg::INT_COUNTS,
  parameter int REF_TIMEOUT = rcc_pkg::REF_TIMEOUT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Rear port
  rcc_link_if.dev link,
  // Front panel, active high while a button is in
  input wire logic [rcc_pkg::MODE_N-1:0] panel_mode_i,
  input wire logic [rcc_pkg::RANGE_N-1:0] panel_range_i,
  // Analog comparator
  input wire logic cmp_eoc_i,
  input wire logic cmp_pol_i,
  // Converter control and display
  output logic [1:0] phase_o,
  output logic [rcc_pkg::MODE_N-1:0] mode_sel_o,
  output logic [rcc_pkg::RANGE_N-1:0] range_sel_o,
  output logic [rcc_pkg::RES_W-1:0] result_o,
  output logic sign_o,
  output logic blank_o
);
  localparam int SYN_W = 4 + rcc_pkg::MODE_N + rcc_pkg::RANGE_N + rcc_pkg::MODE_N + rcc_pkg::RANGE_N;
  localparam int DIV_W = $clog2(MCLK_DIV + 1);

  initial
  begin
    if (MCLK_DIV < 1 || AZ_COUNTS < 1 || INT_COUNTS < 1 || REF_TIMEOUT >= 2 ** rcc_pkg::CNT_W)
    begin
      $error("rcc_device: count parameters out of range");
    end
    if (AZ_COUNTS >= 2 ** rcc_pkg::CNT_W || INT_COUNTS >= 2 ** rcc_pkg::CNT_W)
    begin
      $error("rcc_device: phase counts too wide");
    end
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [SYN_W-1:0] syn1_q;
  logic [SYN_W-1:0] syn2_q;
  logic [SYN_W-1:0] syn_in;
  logic trig_s;
  logic hold_n_s;
  logic eoc_s;
  logic pol_s;
  logic [rcc_pkg::MODE_N-1:0] panel_mode_s;
  logic [rcc_pkg::RANGE_N-1:0] panel_range_s;
  logic [rcc_pkg::MODE_N-1:0] line_mode_s;
  logic [rcc_pkg::RANGE_N-1:0] line_range_s;

  assign syn_in = {link.trigger, link.hold_n, cmp_eoc_i, cmp_pol_i, panel_mode_i, panel_range_i,
                   ~link.mode_n, ~link.range_n};

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      syn1_q <= '0;
      syn2_q <= '0;
    end
    else
    begin
      syn1_q <= syn_in;
      syn2_q <= syn1_q;
    end
  end

  assign {trig_s, hold_n_s, eoc_s, pol_s, panel_mode_s, panel_range_s, line_mode_s, line_range_s} = syn2_q;

  // ----------------------------------------
  // Mode and range selection
  // ----------------------------------------
  // Own pull-down is read back too, so a panel choice stays selected through the line
  logic [rcc_pkg::MODE_N-1:0] mode_sel_d;
  logic [rcc_pkg::MODE_N-1:0] mode_sel_q;
  logic [rcc_pkg::RANGE_N-1:0] range_sel_d;
  logic [rcc_pkg::RANGE_N-1:0] range_sel_q;
  logic [rcc_pkg::MODE_N-1:0] mode_oe_q;
  logic [rcc_pkg::RANGE_N-1:0] range_oe_q;
  logic mode_busy_q;
  logic range_busy_q;

  always_comb
  begin
    mode_sel_d = panel_mode_s | line_mode_s;
    range_sel_d = panel_range_s | line_range_s;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mode_sel_q <= '0;
      range_sel_q <= '0;
      mode_oe_q <= '0;
      range_oe_q <= '0;
      mode_busy_q <= 1'b0;
      range_busy_q <= 1'b0;
    end
    else
    begin
      mode_sel_q <= mode_sel_d;
      range_sel_q <= range_sel_d;
      mode_oe_q <= panel_mode_s;
      range_oe_q <= panel_range_s;
      mode_busy_q <= |panel_mode_s;
      range_busy_q <= |panel_range_s;
    end
  end

  assign link.mode_dev_oe = mode_oe_q;
  assign link.range_dev_oe = range_oe_q;
  assign link.mode_busy = mode_busy_q;
  assign link.range_busy = range_busy_q;
  assign mode_sel_o = mode_sel_q;
  assign range_sel_o = range_sel_q;

  // ----------------------------------------
  // Master count divider
  // ----------------------------------------
  // 20 MHz does not divide exactly to the crystal rate; divisor is a parameter to trim
  logic [DIV_W-1:0] div_d;
  logic [DIV_W-1:0] div_q;
  logic tick;

  always_comb
  begin
    tick = (div_q == DIV_W'(MCLK_DIV - 1));
    div_d = tick ? '0 : div_q + DIV_W'(1);
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_d;
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  rcc_pkg::rcc_phase_e ph_d;
  rcc_pkg::rcc_phase_e ph_q;
  logic [rcc_pkg::CNT_W-1:0] cnt_d;
  logic [rcc_pkg::CNT_W-1:0] cnt_q;
  logic req_d;
  logic req_q;
  logic go;
  logic valid_d;
  logic valid_q;
  logic sign_d;
  logic sign_q;
  logic pol_d;
  logic pol_q;
  logic ready_d;
  logic ready_q;
  logic [rcc_pkg::RES_W-1:0] res_d;
  logic [rcc_pkg::RES_W-1:0] res_q;

  always_comb
  begin
    ph_d = ph_q;
    cnt_d = cnt_q;
    valid_d = valid_q;
    sign_d = sign_q;
    pol_d = pol_q;
    ready_d = ready_q;
    res_d = res_q;
    // Trigger is caught at clock rate so a 1 us pulse is not missed between counts
    go = req_q || trig_s || hold_n_s;
    // Requests are latched only while idle in auto-zero, so a short trigger yields one conversion
    req_d = req_q || (trig_s && ph_q == rcc_pkg::PH_AZ);
    case (ph_q)
      rcc_pkg::PH_AZ:
      begin
        if (tick && cnt_q < rcc_pkg::CNT_W'(AZ_COUNTS))
        begin
          cnt_d = cnt_q + rcc_pkg::CNT_W'(1);
        end
        if (tick && cnt_q >= rcc_pkg::CNT_W'(AZ_COUNTS) && go)
        begin
          ph_d = rcc_pkg::PH_INTEG;
          cnt_d = '0;
          ready_d = 1'b0;
          req_d = 1'b0;
        end
      end
      rcc_pkg::PH_INTEG:
      begin
        if (tick)
        begin
          cnt_d = cnt_q + rcc_pkg::CNT_W'(1);
          if (cnt_q == rcc_pkg::CNT_W'(INT_COUNTS - 1))
          begin
            ph_d = rcc_pkg::PH_DEINT;
            cnt_d = '0;
            pol_d = pol_s;
          end
        end
      end
      rcc_pkg::PH_DEINT:
      begin
        if (eoc_s)
        begin
          ph_d = rcc_pkg::PH_AZ;
          cnt_d = '0;
          res_d = cnt_q[rcc_pkg::RES_W-1:0];
          sign_d = pol_q;
          valid_d = 1'b1;
          ready_d = 1'b1;
        end
        else if (tick)
        begin
          cnt_d = cnt_q + rcc_pkg::CNT_W'(1);
          if (cnt_q == rcc_pkg::CNT_W'(REF_TIMEOUT - 1))
          begin
            ph_d = rcc_pkg::PH_AZ;
            cnt_d = '0;
            sign_d = pol_q;
            valid_d = 1'b0;
            ready_d = 1'b1;
          end
        end
      end
      default:
      begin
        ph_d = rcc_pkg::PH_AZ;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ph_q <= rcc_pkg::PH_AZ;
      cnt_q <= '0;
      req_q <= 1'b0;
      valid_q <= 1'b0;
      sign_q <= 1'b0;
      pol_q <= 1'b0;
      ready_q <= 1'b0;
      res_q <= '0;
    end
    else
    begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      valid_q <= valid_d;
      sign_q <= sign_d;
      pol_q <= pol_d;
      ready_q <= ready_d;
      res_q <= res_d;
    end
  end

  // ----------------------------------------
  // Outputs, rear port mirrors the display
  // ----------------------------------------
  assign phase_o = ph_q;
  assign result_o = res_q;
  assign sign_o = sign_q;
  assign blank_o = ~valid_q;
  assign link.result = res_q;
  assign link.sign = sign_q;
  assign link.data_valid = valid_q;
  assign link.ready = ready_q;
endmodule // rcc_device

//--- logic/rcc_host.sv
`timescale 1ns/1ps
module rcc_host #(
  parameter int TRIG_CYC = rcc_pkg::TRIG_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Rear port
  rcc_link_if.host link,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Interrupt
  output logic irq_o
);
  initial
  begin
    if (TRIG_CYC < rcc_pkg::TRIG_MIN_CYC || TRIG_CYC >= rcc_pkg::TRIG_MAX_CYC)
    begin
      $error("rcc_host: trigger length outside 1 us to 16 ms");
    end
  end

  // ----------------------------------------
  // Link synchronisers
  // ----------------------------------------
  logic [4+rcc_pkg::RES_W-1:0] syn1_q;
  logic [4+rcc_pkg::RES_W-1:0] syn2_q;
  logic mbusy_s;
  logic rbusy_s;
  logic valid_s;
  logic ready_s;
  logic [rcc_pkg::RES_W-1:0] res_s;
  logic ready_old_q;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      syn1_q <= '0;
      syn2_q <= '0;
      ready_old_q <= 1'b0;
    end
    else
    begin
      syn1_q <= {link.mode_busy, link.range_busy, link.data_valid, link.ready, link.result};
      syn2_q <= syn1_q;
      ready_old_q <= ready_s;
    end
  end

  assign {mbusy_s, rbusy_s, valid_s, ready_s, res_s} = syn2_q;

  // ----------------------------------------
  // Registers and trigger timer
  // ----------------------------------------
  // Sign is read through the result word; it changes with the result on the same edge that ready rises
  logic [rcc_pkg::CTRL_W-1:0] ctrl_d;
  logic [rcc_pkg::CTRL_W-1:0] ctrl_q;
  logic [31:0] tcnt_d;
  logic [31:0] tcnt_q;
  logic trig_d;
  logic trig_q;
  logic [rcc_pkg::IRQ_W-1:0] ist_d;
  logic [rcc_pkg::IRQ_W-1:0] ist_q;
  logic [rcc_pkg::IRQ_W-1:0] imask_d;
  logic [rcc_pkg::IRQ_W-1:0] imask_q;
  logic [rcc_pkg::IRQ_W-1:0] ev;
  logic [31:0] rdata_d;
  logic [rcc_pkg::MODE_N-1:0] mreq;
  logic [rcc_pkg::RANGE_N-1:0] rreq;
  logic [rcc_pkg::MODE_N-1:0] moe_q;
  logic [rcc_pkg::RANGE_N-1:0] roe_q;
  logic sign_s1_q;
  logic sign_q;

  assign mreq = ctrl_q[rcc_pkg::CTRL_MODE_LSB +: rcc_pkg::MODE_N];
  assign rreq = ctrl_q[rcc_pkg::CTRL_RANGE_LSB +: rcc_pkg::RANGE_N];

  always_comb
  begin
    ctrl_d = ctrl_q;
    tcnt_d = tcnt_q;
    imask_d = imask_q;
    if (tcnt_q != 32'h00000000)
    begin
      tcnt_d = tcnt_q - 32'h00000001;
    end
    if (wr_i && addr_i == rcc_pkg::REG_CTRL)
    begin
      ctrl_d = wdata_i[rcc_pkg::CTRL_W-1:0];
      if (wdata_i[rcc_pkg::CTRL_START])
      begin
        tcnt_d = 32'(TRIG_CYC);
      end
    end
    if (wr_i && addr_i == rcc_pkg::REG_IRQ_MASK)
    begin
      imask_d = wdata_i[rcc_pkg::IRQ_W-1:0];
    end
    trig_d = ctrl_d[rcc_pkg::CTRL_CONT] || (tcnt_d != 32'h00000000);
    ev = '0;
    ev[rcc_pkg::IRQ_DONE] = ready_s && !ready_old_q && valid_s;
    ev[rcc_pkg::IRQ_OVER] = ready_s && !ready_old_q && !valid_s;
    ev[rcc_pkg::IRQ_BLOCK] = (|mreq && mbusy_s) || (|rreq && rbusy_s);
    ist_d = ist_q;
    if (rd_i && addr_i == rcc_pkg::REG_IRQ_STAT)
    begin
      ist_d = '0;
    end
    ist_d = ist_d | ev;
    rdata_d = 32'h00000000;
    if (rd_i)
    begin
      case (addr_i)
        rcc_pkg::REG_CTRL: rdata_d = 32'(ctrl_q);
        rcc_pkg::REG_STAT: rdata_d = {26'h0000000, trig_q, sign_q, ready_s, valid_s, rbusy_s, mbusy_s};
        rcc_pkg::REG_RESULT: rdata_d = {16'h0000, sign_q, res_s};
        rcc_pkg::REG_IRQ_STAT: rdata_d = 32'(ist_q);
        rcc_pkg::REG_IRQ_MASK: rdata_d = 32'(imask_q);
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_q <= rcc_pkg::CTRL_RESET;
      tcnt_q <= '0;
      trig_q <= 1'b0;
      ist_q <= '0;
      imask_q <= '0;
      rdata_o <= '0;
      moe_q <= '0;
      roe_q <= '0;
      sign_s1_q <= 1'b0;
      sign_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      tcnt_q <= tcnt_d;
      trig_q <= trig_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      rdata_o <= rdata_d;
      moe_q <= mbusy_s ? '0 : mreq;
      roe_q <= rbusy_s ? '0 : rreq;
      sign_s1_q <= link.sign;
      sign_q <= sign_s1_q;
    end
  end

  assign link.trigger = trig_q;
  assign link.hold_n = ~ctrl_q[rcc_pkg::CTRL_HOLD];
  assign link.mode_host_oe = moe_q;
  assign link.range_host_oe = roe_q;
  assign irq_o = |(ist_q & imask_q);
endmodule // rcc_host

//--- sim/rcc_assertions.sv
`timescale 1ns/1ps
module rcc_assertions #(
  parameter int MCLK_DIV = 4,
  parameter int AZ_COUNTS = 8,
  parameter int INT_COUNTS = 8,
  parameter int REF_TIMEOUT = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Rear port
  input wire logic trigger,
  input wire logic hold_n,
  input wire logic [rcc_pkg::MODE_N-1:0] mode_dev_oe,
  input wire logic [rcc_pkg::MODE_N-1:0] mode_host_oe,
  input wire logic [rcc_pkg::RANGE_N-1:0] range_dev_oe,
  input wire logic [rcc_pkg::RANGE_N-1:0] range_host_oe,
  input wire logic mode_busy,
  input wire logic range_busy,
  input wire logic data_valid,
  input wire logic ready,
  input wire logic [rcc_pkg::RES_W-1:0] result
);
  // Slack covers the input synchronisers and a partly run auto-zero
  localparam int CONV_MAX = MCLK_DIV * (AZ_COUNTS + INT_COUNTS + REF_TIMEOUT + 4) + 16;
  localparam int INT_CYC = MCLK_DIV * INT_COUNTS;
  int trig_q, trig_d, run_q, run_d, quiet_q, quiet_d, conv_q, conv_d;
  logic rdy_q;
  always_comb
  begin
    trig_d = trigger ? trig_q + 1 : 0;
    run_d = ((trigger || hold_n) && !(ready && !rdy_q)) ? run_q + 1 : 0;
    quiet_d = (!trigger && !hold_n) ? quiet_q + 1 : 0;
    conv_d = ready ? 0 : conv_q + 1;
  end
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      trig_q <= 0;
      run_q <= 0;
      quiet_q <= 0;
      conv_q <= 0;
      rdy_q <= 1'b0;
    end
    else
    begin
      trig_q <= trig_d;
      run_q <= run_d;
      quiet_q <= quiet_d;
      conv_q <= conv_d;
      rdy_q <= ready;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_TRIG_MIN: assert property ($fell(trigger) |-> trig_q >= rcc_pkg::TRIG_MIN_CYC)
    else $error("Trigger pulse too short");
  AST_TRIG_MAX: assert property ($fell(trigger) |-> trig_q <= rcc_pkg::TRIG_MAX_CYC)
    else $error("Trigger pulse too long");
  AST_RUN_REPEAT: assert property ((trigger || hold_n) |-> run_q < CONV_MAX)
    else $error("No conversion end while requested");
  AST_HOLD_QUIET: assert property (quiet_q > CONV_MAX |-> !$fell(ready))
    else $error("Conversion started while held");
  AST_INTEG_SPAN: assert property ($rose(ready) |-> conv_q >= INT_CYC)
    else $error("Integration phase too short");
  AST_RESULT_HOLD: assert property (!ready |-> $stable(result) && $stable(data_valid))
    else $error("Result changed outside conversion end");
  AST_MODE_BUSY_SET: assert property ($rose(|mode_dev_oe) |-> ##[0:3] mode_busy)
    else $error("Mode status not raised");
  AST_MODE_FREE: assert property ($fell(|mode_dev_oe) |-> ##[0:3] !mode_busy)
    else $error("Mode status not released");
  AST_RANGE_FREE: assert property ($fell(|range_dev_oe) |-> ##[0:3] !range_busy)
    else $error("Range status not released");
  AST_HOST_BLOCK: assert property ($rose(|mode_host_oe) |-> !$past(mode_busy))
    else $error("Mode pulled while panel busy");
  cover property ($rose(ready) && data_valid);
  cover property ($rose(ready) && !data_valid);
  cover property ($rose(|mode_host_oe));
  cover property ($rose(range_busy) || $rose(mode_busy));
endmodule // rcc_assertions

//--- sim/rcc_tb.sv
`timescale 1ns/1ps
module rcc_tb;
  localparam int DIV = 4;
  localparam int CNT = 8;
  localparam int TMO = 16;
  localparam int EOC_AT = 40;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o;
  logic [rcc_pkg::MODE_N-1:0] panel_mode_i = 4'h0;
  logic [rcc_pkg::RANGE_N-1:0] panel_range_i = 7'h00;
  logic cmp_eoc_i = 1'b0;
  logic cmp_pol_i = 1'b1;
  logic eoc_en = 1'b1;
  logic [1:0] phase_o;
  logic [rcc_pkg::MODE_N-1:0] mode_sel_o;
  logic [rcc_pkg::RANGE_N-1:0] range_sel_o;
  logic [rcc_pkg::RES_W-1:0] result_o;
  logic sign_o;
  logic blank_o;
  logic [31:0] rv;
  int ref_cyc = 0;
  int num_errors = 0;
  int cmp_count = 0;
  rcc_link_if link ();
  rcc_device #(.MCLK_DIV(DIV), .AZ_COUNTS(CNT), .INT_COUNTS(CNT), .REF_TIMEOUT(TMO)) i_rcc_device (
    .clk_i(clk_i), .resetn_i(resetn_i), .link(link), .panel_mode_i(panel_mode_i),
    .panel_range_i(panel_range_i), .cmp_eoc_i(cmp_eoc_i), .cmp_pol_i(cmp_pol_i), .phase_o(phase_o),
    .mode_sel_o(mode_sel_o), .range_sel_o(range_sel_o), .result_o(result_o), .sign_o(sign_o), .blank_o(blank_o));
  rcc_host #(.TRIG_CYC(20)) i_rcc_host (.clk_i(clk_i), .resetn_i(resetn_i), .link(link), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
  rcc_assertions #(.MCLK_DIV(DIV), .AZ_COUNTS(CNT), .INT_COUNTS(CNT), .REF_TIMEOUT(TMO)) i_rcc_assertions (
    .clk_i(clk_i), .resetn_i(resetn_i), .trigger(link.trigger), .hold_n(link.hold_n),
    .mode_dev_oe(link.mode_dev_oe), .mode_host_oe(link.mode_host_oe), .range_dev_oe(link.range_dev_oe),
    .range_host_oe(link.range_host_oe), .mode_busy(link.mode_busy), .range_busy(link.range_busy),
    .data_valid(link.data_valid), .ready(link.ready), .result(link.result));
  always #25 clk_i = ~clk_i;
  // Comparator stand-in: zero crossing a fixed time into the reference phase
  always @(posedge clk_i)
  begin
    ref_cyc <= (phase_o == rcc_pkg::PH_DEINT) ? ref_cyc + 1 : 0;
    cmp_eoc_i <= eoc_en && (phase_o == rcc_pkg::PH_DEINT) && (ref_cyc >= EOC_AT);
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    rv = rdata_o;
  endtask
  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (link.ready !== v && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000)
    begin
      num_errors++;
      wrap_up();
    end
    #1;
  endtask
  task automatic wait_conv();
    wait_lvl(1'b0);
    wait_lvl(1'b1);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    chk(blank_o, 1'b1);
    chk(link.hold_n, 1'b1);
    rd(rcc_pkg::REG_CTRL);
    chk(rv, 32'h0);
    rd(8'h14);
    chk(rv, 32'h0);
    $display("Test reset done");
    wait_lvl(1'b1);
    wr(rcc_pkg::REG_CTRL, 32'h800);
    chk(link.hold_n, 1'b0);
    settle(400);
    chk(phase_o, rcc_pkg::PH_AZ);
    chk(link.ready, 1'b1);
    rd(rcc_pkg::REG_IRQ_STAT);
    chk(rv, 32'h1);
    $display("Test hold done");
    wr(rcc_pkg::REG_CTRL, 32'h2800);
    chk(link.trigger, 1'b1);
    wait_conv();
    chk(link.data_valid, 1'b1);
    chk(blank_o, 1'b0);
    chk(link.result, result_o);
    chk(result_o >= 15'h0009 && result_o <= 15'h000C, 1'b1);
    rd(rcc_pkg::REG_RESULT);
    chk(rv, {16'h0, sign_o, result_o});
    chk(link.trigger, 1'b0);
    settle(400);
    chk(phase_o, rcc_pkg::PH_AZ);
    $display("Test single done");
    eoc_en <= 1'b0;
    rd(rcc_pkg::REG_IRQ_STAT);
    chk(rv, 32'h1);
    wr(rcc_pkg::REG_IRQ_MASK, 32'h2);
    wr(rcc_pkg::REG_CTRL, 32'h2800);
    wait_conv();
    chk(link.data_valid, 1'b0);
    chk(blank_o, 1'b1);
    settle(4);
    chk(irq_o, 1'b1);
    rd(rcc_pkg::REG_IRQ_STAT);
    chk(rv, 32'h2);
    settle(2);
    chk(irq_o, 1'b0);
    eoc_en <= 1'b1;
    $display("Test timeout done");
    wr(rcc_pkg::REG_CTRL, 32'h1800);
    chk(link.trigger, 1'b1);
    repeat (3)
    begin
      wait_conv();
      chk(link.data_valid, 1'b1);
    end
    wr(rcc_pkg::REG_CTRL, 32'h800);
    chk(link.trigger, 1'b0);
    settle(400);
    $display("Test repeat done");
    panel_mode_i <= 4'h2;
    settle(4);
    chk(link.mode_busy, 1'b1);
    chk(link.mode_n, 4'hD);
    chk(mode_sel_o, 4'h2);
    chk(link.range_busy, 1'b0);
    wr(rcc_pkg::REG_CTRL, 32'h880);
    settle(4);
    chk(link.range_n, 7'h77);
    chk(range_sel_o, 7'h08);
    chk(mode_sel_o, 4'h2);
    wr(rcc_pkg::REG_CTRL, 32'h884);
    chk(link.mode_host_oe, 4'h0);
    rd(rcc_pkg::REG_IRQ_STAT);
    chk(rv[2], 1'b1);
    panel_mode_i <= 4'h0;
    settle(4);
    chk(link.mode_busy, 1'b0);
    wr(rcc_pkg::REG_CTRL, 32'h884);
    settle(4);
    chk(link.mode_n, 4'hB);
    chk(mode_sel_o, 4'h4);
    settle(4);
    rd(rcc_pkg::REG_STAT);
    chk(rv[1:0], 2'b00);
    $display("Test select done");
    wrap_up();
  end
endmodule // rcc_tb
